// [shared/pmf_consts.svh]
`ifndef PMF_CONSTS_SVH
`define PMF_CONSTS_SVH
`define PMF_MC_NUM 16
`define PMF_PT_NUM 5
`define PMF_TERM_NUM 80
`define PMF_CHAIN_LEN 8
`define PMF_MAX_SETS 3
`define PMF_OE_NUM 6
`define PMF_OE_SRC_NUM 34
`define PMF_ROUTE_MASK 52'h0_000F_FFFF_FFFF
// Register offsets
`define PMF_CTRL_OFS 12'h000
`define PMF_STAT_OFS 12'h004
`define PMF_ROUTE_LO_OFS 12'h008
`define PMF_ROUTE_HI_OFS 12'h00C
`define PMF_GCLK_OFS 12'h010
`define PMF_PINS_OFS 12'h014
`define PMF_OE_BASE 12'h040
`define PMF_MC_BASE 12'h080
`define PMF_MC_END 12'h0C0
`define PMF_PT_BASE 12'h400
`define PMF_PT_END 12'h900
// Macrocell configuration fields
`define PMF_F_PRIM 4:0
`define PMF_F_XINV 5
`define PMF_F_FF 8:6
`define PMF_F_CLK 10:9
`define PMF_F_GSEL 11
`define PMF_F_GCLR 12
`define PMF_F_PWR 13
`define PMF_F_FAST 14
`define PMF_F_FPIN 18:15
`define PMF_F_FDLY 19
`define PMF_F_SETS 21:20
`define PMF_F_LEND 22
`define PMF_F_SHARE 23
`define PMF_F_OESEL 27:24
`endif

// [shared/pmf_pkg.sv]
package pmf_pkg;
    typedef enum logic [2:0] {FF_D, FF_T, FF_JK, FF_SR, FF_COMB} pmf_ff_t;
    typedef enum logic [1:0] {CK_GLOBAL, CK_GLOBAL_EN, CK_ARRAY} pmf_clk_t;
endpackage

// [src/pmf_fabric.sv]
`timescale 1ns/100ps
`include "pmf_consts.svh"
module pmf_fabric #(
    parameter int NUM_OE = `PMF_OE_NUM
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Dedicated inputs
    input wire logic global_clock_pin_one,
    input wire logic global_clock_pin_two,
    input wire logic global_clear_pin_low,
    input wire logic global_oe_pin_one,
    // User I/O pins
    input wire logic [15:0] io_in,
    output logic [15:0] io_out,
    output logic [15:0] io_oe
);
    typedef struct packed {
        logic ready;
        logic resp;
        logic [31:0] rdata;
        logic dph_wr;
        logic [11:0] dph_addr;
        logic run;
        logic [35:0] route_en;
        logic [3:0] gclk_cfg;
        logic [NUM_OE-1:0][6:0] oe_cfg;
        logic [15:0][27:0] mc_cfg;
        logic [79:0][51:0] tmask;
        logic [79:0][51:0] cmask;
        logic [15:0] mc_q;
        logic [15:0] fast_dly;
        logic [15:0] aclk_prev;
        logic [15:0] oe_q;
        logic [15:0] pin_q;
        logic [1:0] gclk_prev;
    } pmf_state_t;

    pmf_state_t st_r;
    pmf_state_t st_nxt;

    function automatic logic pmf_term(input logic [51:0] lit, input logic [51:0] t,
                                      input logic [51:0] c);
        return (&(lit | ~t)) & (&(~lit | ~c));
    endfunction

    // Word slot of an address above a region base
    function automatic int pmf_slot(input logic [11:0] a, input logic [11:0] base);
        return int'(a - base) >> 2;
    endfunction

    function automatic logic pmf_in(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
        return (a >= lo) && (a < hi);
    endfunction

    logic [11:0] oe_end;
    assign oe_end = `PMF_OE_BASE + 12'(4 * NUM_OE);

    always_comb begin
        logic [11:0] a;
        logic [31:0] rd;
        logic [3:0] ded;
        logic [35:0] route;
        logic [15:0] sexp;
        logic [51:0] lit;
        logic [15:0][4:0] pt;
        logic [15:0][4:0] sec;
        logic [15:0] own;
        logic [15:0] lend;
        logic [1:0] gnet;
        logic [1:0] gedge;
        logic [33:0] oe_src;
        logic [NUM_OE-1:0] oe_net;
        logic d;
        logic edge_ok;
        logic nq;
        logic clr;
        logic [4:0] pm;
        int ti;
        int sel;
        a = '0;
        rd = '0;
        ded = '0;
        route = '0;
        sexp = '0;
        lit = '0;
        pt = '0;
        sec = '0;
        own = '0;
        lend = '0;
        gnet = '0;
        gedge = '0;
        oe_src = '0;
        oe_net = '0;
        d = 1'b0;
        edge_ok = 1'b0;
        nq = 1'b0;
        clr = 1'b0;
        pm = '0;
        ti = 0;
        sel = 0;
        st_nxt = st_r;
        st_nxt.ready = 1'b1;
        st_nxt.resp = 1'b0;
        st_nxt.pin_q = io_in;

        // Dedicated inputs double as plain logic inputs on the bus
        ded = {global_oe_pin_one, global_clear_pin_low, global_clock_pin_two,
               global_clock_pin_one};
        route = {st_r.mc_q, io_in, ded} & st_r.route_en;
        for (int m = 0; m < `PMF_MC_NUM; m++) begin
            ti = m * `PMF_PT_NUM + 4;
            // Expanders see only routed inputs, so no loop through themselves
            if (st_r.mc_cfg[m][`PMF_F_SHARE])
                sexp[m] = ~pmf_term({16'h0, route}, st_r.tmask[ti] & `PMF_ROUTE_MASK,
                                    st_r.cmask[ti] & `PMF_ROUTE_MASK);
        end
        lit = {sexp, route};
        for (int m = 0; m < `PMF_MC_NUM; m++) begin
            pm = st_r.mc_cfg[m][`PMF_F_PRIM];
            if (st_r.mc_cfg[m][`PMF_F_SHARE])
                pm[4] = 1'b0;
            for (int p = 0; p < `PMF_PT_NUM; p++) begin
                ti = m * `PMF_PT_NUM + p;
                pt[m][p] = pmf_term(lit, st_r.tmask[ti], st_r.cmask[ti]);
            end
            own[m] = |(pt[m] & pm);
            sec[m] = pt[m] & ~st_r.mc_cfg[m][`PMF_F_PRIM];
            // Top of a chain never lends
            lend[m] = st_r.mc_cfg[m][`PMF_F_LEND] && (m % `PMF_CHAIN_LEN != 7);
        end

        for (int g = 0; g < 2; g++) begin
            gnet[g] = (st_r.gclk_cfg[2*g] ? global_clock_pin_two : global_clock_pin_one)
                      ^ st_r.gclk_cfg[2*g+1];
            gedge[g] = gnet[g] & ~st_r.gclk_prev[g];
        end
        st_nxt.gclk_prev = gnet;

        if (st_r.run) begin
            for (int m = 0; m < `PMF_MC_NUM; m++) begin
                d = lend[m] ? 1'b0 : own[m];
                for (int k = 1; k <= `PMF_MAX_SETS; k++) begin
                    if (k <= int'(st_r.mc_cfg[m][`PMF_F_SETS]) && (m % `PMF_CHAIN_LEN) >= k
                        && lend[(m + `PMF_MC_NUM - k) % `PMF_MC_NUM])
                        d = d | own[(m + `PMF_MC_NUM - k) % `PMF_MC_NUM];
                end
                d = d ^ st_r.mc_cfg[m][`PMF_F_XINV];
                st_nxt.fast_dly[m] = io_in[st_r.mc_cfg[m][`PMF_F_FPIN]];
                if (st_r.mc_cfg[m][`PMF_F_FAST])
                    d = st_r.mc_cfg[m][`PMF_F_FDLY] ? st_r.fast_dly[m]
                        : io_in[st_r.mc_cfg[m][`PMF_F_FPIN]];
                st_nxt.aclk_prev[m] = sec[m][0];
                case (pmf_pkg::pmf_clk_t'(st_r.mc_cfg[m][`PMF_F_CLK]))
                    pmf_pkg::CK_GLOBAL: begin
                        edge_ok = gedge[st_r.mc_cfg[m][`PMF_F_GSEL]];
                    end
                    pmf_pkg::CK_GLOBAL_EN: begin
                        edge_ok = gedge[st_r.mc_cfg[m][`PMF_F_GSEL]] & sec[m][0];
                    end
                    pmf_pkg::CK_ARRAY: begin
                        edge_ok = sec[m][0] & ~st_r.aclk_prev[m];
                    end
                    default: begin
                        edge_ok = 1'b0;
                    end
                endcase
                nq = st_r.mc_q[m];
                case (pmf_pkg::pmf_ff_t'(st_r.mc_cfg[m][`PMF_F_FF]))
                    pmf_pkg::FF_D: begin
                        if (edge_ok) nq = d;
                    end
                    pmf_pkg::FF_T: begin
                        if (edge_ok) nq = st_r.mc_q[m] ^ d;
                    end
                    pmf_pkg::FF_JK: begin
                        if (edge_ok) begin
                            case ({d, sec[m][3]})
                                2'b10: nq = 1'b1;
                                2'b01: nq = 1'b0;
                                2'b11: nq = ~st_r.mc_q[m];
                                default: nq = st_r.mc_q[m];
                            endcase
                        end
                    end
                    pmf_pkg::FF_SR: begin
                        if (edge_ok && d != sec[m][3]) nq = d;
                    end
                    pmf_pkg::FF_COMB: begin
                        nq = d;
                    end
                    default: begin
                        nq = st_r.mc_q[m];
                    end
                endcase
                clr = sec[m][1] | (st_r.mc_cfg[m][`PMF_F_GCLR] & ~global_clear_pin_low);
                if (clr)
                    nq = 1'b0;
                else if (sec[m][2])
                    nq = 1'b1;
                st_nxt.mc_q[m] = nq;
            end
        end

        oe_src = {st_r.mc_q, io_in, global_clock_pin_two, global_oe_pin_one};
        for (int k = 0; k < NUM_OE; k++) begin
            if (int'(st_r.oe_cfg[k][5:0]) < `PMF_OE_SRC_NUM)
                oe_net[k] = oe_src[st_r.oe_cfg[k][5:0]] ^ st_r.oe_cfg[k][6];
        end
        for (int m = 0; m < `PMF_MC_NUM; m++) begin
            sel = int'(st_r.mc_cfg[m][`PMF_F_OESEL]);
            if (!st_r.run || sel == 0)
                st_nxt.oe_q[m] = 1'b0;
            else if (sel == 1)
                st_nxt.oe_q[m] = 1'b1;
            else
                st_nxt.oe_q[m] = (sel - 2 < NUM_OE) ? oe_net[sel-2] : 1'b0;
        end

        // Data phase write; configuration is frozen while the fabric runs
        if (st_r.dph_wr) begin
            a = st_r.dph_addr;
            if (a == `PMF_CTRL_OFS) begin
                st_nxt.run = hwdata[0];
                if (hwdata[0] && !st_r.run) begin
                    for (int m = 0; m < `PMF_MC_NUM; m++)
                        st_nxt.mc_q[m] = st_r.mc_cfg[m][`PMF_F_PWR];
                    st_nxt.gclk_prev = gnet;
                    st_nxt.aclk_prev = '1;
                end
            end else if (!st_r.run) begin
                if (a == `PMF_ROUTE_LO_OFS)
                    st_nxt.route_en[31:0] = hwdata;
                else if (a == `PMF_ROUTE_HI_OFS)
                    st_nxt.route_en[35:32] = hwdata[3:0];
                else if (a == `PMF_GCLK_OFS)
                    st_nxt.gclk_cfg = hwdata[3:0];
                else if (pmf_in(a, `PMF_OE_BASE, oe_end))
                    st_nxt.oe_cfg[pmf_slot(a, `PMF_OE_BASE)] = hwdata[6:0];
                else if (pmf_in(a, `PMF_MC_BASE, `PMF_MC_END))
                    st_nxt.mc_cfg[pmf_slot(a, `PMF_MC_BASE)] = hwdata[27:0];
                else if (pmf_in(a, `PMF_PT_BASE, `PMF_PT_END)) begin
                    ti = pmf_slot(a, `PMF_PT_BASE) >> 2;
                    case (a[3:2])
                        2'd0: st_nxt.tmask[ti][31:0] = hwdata;
                        2'd1: st_nxt.tmask[ti][51:32] = hwdata[19:0];
                        2'd2: st_nxt.cmask[ti][31:0] = hwdata;
                        default: st_nxt.cmask[ti][51:32] = hwdata[19:0];
                    endcase
                end
            end
        end

        // Address phase: read data is fetched now so hrdata comes from a flop
        st_nxt.dph_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            a = haddr[11:0];
            st_nxt.dph_wr = hwrite;
            st_nxt.dph_addr = a;
            if (a == `PMF_CTRL_OFS)
                rd = {31'h0, st_r.run};
            else if (a == `PMF_STAT_OFS)
                rd = {16'h0, st_r.mc_q};
            else if (a == `PMF_ROUTE_LO_OFS)
                rd = st_r.route_en[31:0];
            else if (a == `PMF_ROUTE_HI_OFS)
                rd = {28'h0, st_r.route_en[35:32]};
            else if (a == `PMF_GCLK_OFS)
                rd = {28'h0, st_r.gclk_cfg};
            else if (a == `PMF_PINS_OFS)
                rd = {st_r.oe_q, st_r.pin_q};
            else if (pmf_in(a, `PMF_OE_BASE, oe_end))
                rd = {25'h0, st_r.oe_cfg[pmf_slot(a, `PMF_OE_BASE)]};
            else if (pmf_in(a, `PMF_MC_BASE, `PMF_MC_END))
                rd = {4'h0, st_r.mc_cfg[pmf_slot(a, `PMF_MC_BASE)]};
            else if (pmf_in(a, `PMF_PT_BASE, `PMF_PT_END)) begin
                ti = pmf_slot(a, `PMF_PT_BASE) >> 2;
                case (a[3:2])
                    2'd0: rd = st_r.tmask[ti][31:0];
                    2'd1: rd = {12'h0, st_r.tmask[ti][51:32]};
                    2'd2: rd = st_r.cmask[ti][31:0];
                    default: rd = {12'h0, st_r.cmask[ti][51:32]};
                endcase
            end
            st_nxt.rdata = rd;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout = st_r.ready;
    assign hresp = st_r.resp;
    assign hrdata = st_r.rdata;
    assign io_out = st_r.mc_q;
    assign io_oe = st_r.oe_q;
endmodule

// [bench/pmf_board.sv]
`timescale 1ns/100ps
module pmf_board (
    // Device side of the pins
    input wire logic [15:0] io_out,
    input wire logic [15:0] io_oe,
    // Board side
    input wire logic [15:0] drive,
    output logic [15:0] io_in
);
    // Board yields wherever the device drives, so no pin is ever fought over
    assign io_in = (io_out & io_oe) | (drive & ~io_oe);
endmodule

// [bench/pmf_fabric_chk.sv]
`timescale 1ns/100ps
`include "pmf_consts.svh"
module pmf_fabric_chk #(
    parameter int NUM_OE = 6
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Dedicated inputs
    input wire logic global_clock_pin_one,
    input wire logic global_clock_pin_two,
    input wire logic global_clear_pin_low,
    input wire logic global_oe_pin_one,
    // Pins
    input wire logic [15:0] io_in,
    input wire logic [15:0] io_out,
    input wire logic [15:0] io_oe
);
    logic run_r, ctl_wr_r, gck_wr_r;
    logic [3:0] gck_r;
    wire taken = hsel && htrans[1] && hready;
    // Shadow of run and clock select, tracked from completed writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r <= 1'b0;
            ctl_wr_r <= 1'b0;
            gck_wr_r <= 1'b0;
            gck_r <= 4'h0;
        end else begin
            ctl_wr_r <= taken && hwrite && haddr[11:0] == `PMF_CTRL_OFS;
            gck_wr_r <= taken && hwrite && haddr[11:0] == `PMF_GCLK_OFS;
            if (ctl_wr_r) run_r <= hwdata[0];
            if (gck_wr_r && !run_r) gck_r <= hwdata[3:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [11:0] a);
        taken && !hwrite && haddr[11:0] == a;
    endsequence
    sequence s_idle;
        !run_r [*4];
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("wait state seen");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_rdata_stands: assert property (!taken |=> $stable(hrdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (s_rd(12'h018) |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (s_rd(`PMF_CTRL_OFS) |=> hrdata[0] == $past(run_r))
        else $error("run bit readback");
    a_gclk_readback: assert property (s_rd(`PMF_GCLK_OFS) |=> hrdata[3:0] == $past(gck_r))
        else $error("clock select readback");
    a_oe_stopped: assert property (s_idle |-> io_oe == 16'h0000)
        else $error("pin driven while stopped");
    a_out_holds: assert property (s_idle |-> $stable(io_out))
        else $error("output moved while stopped");
endmodule
bind pmf_fabric pmf_fabric_chk #(.NUM_OE(NUM_OE)) u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .global_clock_pin_one, .global_clock_pin_two,
    .global_clear_pin_low, .global_oe_pin_one, .io_in, .io_out, .io_oe
);

// [bench/pmf_fabric_test.sv]
`timescale 1ns/100ps
`include "pmf_consts.svh"
module pmf_fabric_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic pin_one, pin_two, clr_low, oe_one;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] io_in, io_out, io_oe, drive;
    int bad_count, compares;
    // Pins 8..11 and 13..15 stay inputs: A on 8, B on 9, enable E on 10
    localparam logic [11:0] cfg_a [10] = '{12'h080, 12'h084, 12'h08C, 12'h090,
        12'h094, 12'h400, 12'h450, 12'h4F0, 12'h540, 12'h550};
    localparam logic [31:0] cfg_d [10] = '{32'h0100_0101, 32'h0100_0121,
        32'h0100_1001, 32'h0100_0202, 32'h0100_2000, 32'h0000_1000,
        32'h0000_1000, 32'h0000_2000, 32'h0000_4000, 32'h0000_2000};
    // An empty term is true, so clear and preset terms of the cells above are forced low
    localparam int zero_t [9] = '{1, 2, 6, 7, 16, 17, 22, 26, 27};
    // Second set: 6 lends A to 7 (own terms B), 8 cleared by A and preset by oe pin one,
    // 9 shares ~E with 10, 11 takes pin B by the delayed fast path, 12 enabled by net 0
    localparam logic [11:0] cfg2_a [16] = '{12'h098, 12'h09C, 12'h0A0, 12'h0A4, 12'h0A8,
        12'h0AC, 12'h0B0, 12'h040, 12'h5E0, 12'h640, 12'h650, 12'h690, 12'h6A0, 12'h710,
        12'h734, 12'h744};
    localparam logic [31:0] cfg2_d [16] = '{32'h0040_0001, 32'h0010_0106, 32'h0000_0100,
        32'h0080_0000, 32'h0000_0106, 32'h000C_C106, 32'h0200_0000, 32'h0000_0040,
        32'h0000_1000, 32'h0000_2000, 32'h0000_2000, 32'h0000_1000, 32'h0000_0008,
        32'h0000_4000, 32'h0000_2000, 32'h0000_2000};
    pmf_fabric #(.NUM_OE(`PMF_OE_NUM)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .global_clock_pin_one(pin_one), .global_clock_pin_two(pin_two),
        .global_clear_pin_low(clr_low), .global_oe_pin_one(oe_one),
        .io_in, .io_out, .io_oe
    );
    pmf_board board (.io_out, .io_oe, .drive, .io_in);
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic tally_and_finish;
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        chk(r, e);
    endtask
    // One global clock edge on pin one, long enough for the edge detector
    task automatic pulse;
        pin_one <= 1'b1;
        cyc(3);
        pin_one <= 1'b0;
        cyc(3);
    endtask
    initial begin
        cyc(4000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        {pin_one, pin_two, oe_one} = 3'b000;
        clr_low = 1'b1;
        drive = 16'h0000;
        bad_count = 0;
        compares = 0;
        cyc(12);
        hresetn <= 1'b1;
        cyc(1);
        rc(`PMF_CTRL_OFS, 32'h0000_0000);
        rc(`PMF_STAT_OFS, 32'h0000_0000);
        wr(12'h018, 32'hFFFF_FFFF);
        rc(12'h018, 32'h0000_0000);
        wr(`PMF_GCLK_OFS, 32'h0000_000A);
        rc(`PMF_GCLK_OFS, 32'h0000_000A);
        wr(`PMF_GCLK_OFS, 32'h0000_0000);
        wr(`PMF_ROUTE_LO_OFS, 32'hFFFF_FFFF);
        wr(`PMF_ROUTE_HI_OFS, 32'h0000_000F);
        for (int i = 0; i < 10; i++) begin
            wr(cfg_a[i], cfg_d[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wr(32'h0000_0400 + 32'(16 * zero_t[i]), 32'h0000_0001);
            wr(32'h0000_0408 + 32'(16 * zero_t[i]), 32'h0000_0001);
        end
        rc(12'h08C, 32'h0100_1001);
        drive <= 16'h0100;
        wr(`PMF_CTRL_OFS, 32'h0000_0001);
        cyc(3);
        chk({16'h0000, io_out}, 32'h0000_0021);
        chk({16'h0000, io_oe}, 32'h0000_003B);
        rc(`PMF_STAT_OFS, 32'h0000_0021);
        drive <= 16'h0000;
        cyc(3);
        chk({16'h0000, io_out}, 32'h0000_0022);
        drive <= 16'h0200;
        cyc(2);
        pulse();
        chk({16'h0000, io_out}, 32'h0000_000A);
        drive <= 16'h0600;
        cyc(2);
        pulse();
        chk({16'h0000, io_out}, 32'h0000_001A);
        clr_low <= 1'b0;
        cyc(3);
        chk({16'h0000, io_out}, 32'h0000_0012);
        clr_low <= 1'b1;
        wr(`PMF_GCLK_OFS, 32'h0000_0002);
        rc(`PMF_GCLK_OFS, 32'h0000_0000);
        rc(`PMF_CTRL_OFS, 32'h0000_0001);
        wr(`PMF_CTRL_OFS, 32'h0000_0000);
        cyc(4);
        chk({16'h0000, io_oe}, 32'h0000_0000);
        pulse();
        chk({16'h0000, io_out}, 32'h0000_0012);
        for (int i = 0; i < 16; i++) begin
            wr(cfg2_a[i], cfg2_d[i]);
        end
        drive <= 16'h0100;
        wr(`PMF_CTRL_OFS, 32'h0000_0001);
        cyc(3);
        chk({16'h0000, io_out}, 32'h0000_04A1);
        chk({16'h0000, io_oe}, 32'h0000_103B);
        drive <= 16'h0600;
        oe_one <= 1'b1;
        cyc(3);
        chk({16'h0000, io_out}, 32'h0000_09A2);
        chk({16'h0000, io_oe}, 32'h0000_003B);
        drive <= 16'h0000;
        cyc(3);
        chk({16'h0000, io_out}, 32'h0000_0522);
        tally_and_finish();
    end
endmodule
